/* File: verilog/aac_pkg.sv */
// Purpose: constants, types and helpers of the auxiliary converter block
// Assumes: 16-bit registers reached by 8-bit register index
// Notes:   shared by aac_regs and aac_rate_div
// Functional notes
// RULE1: pressure result bit 15 shows pen contact sensed before that measurement.
// RULE2: pressure result bits 11:0 hold the measurement, zero after reset.
// RULE3: aux result holds 12-bit value, bits 13:12 tag its source channel.
// RULE4: automatic conversions run only while enabled, rate nonzero, go bit set.
// RULE5: manual mode: host sets go bit, device starts one conversion, clears it.
// RULE6: rate code zero is manual, otherwise conversions at code times 16 Hz.
// RULE7: select bits 8, 1, 0 include supply, second and first input.
// RULE8: config bit 9 routes supply measurement point to first aux pin.
// RULE9: config bit 8 picks supply divider 0.45 or 0.41, resets to one.
// RULE10: config bits 1, 0 pick reference: half regulator or 1.5 V bandgap.
// RULE11: channels are stepped in fixed order, value and tag update together.
// RULE12: host writes to result registers are ignored.
package aac_pkg;

	// register indices
	localparam logic [7:0] AAC_IDX_PRESSURE = 8'h3b;
	localparam logic [7:0] AAC_IDX_RESULT   = 8'h3c;
	localparam logic [7:0] AAC_IDX_CONTROL  = 8'h3d;
	localparam logic [7:0] AAC_IDX_SELECT   = 8'h3e;
	localparam logic [7:0] AAC_IDX_CONFIG   = 8'h3f;

	// field positions
	localparam int AAC_BIT_PEN      = 15;
	localparam int AAC_BIT_ON       = 15;
	localparam int AAC_BIT_GO       = 14;
	localparam int AAC_BIT_SUPPLY   = 8;
	localparam int AAC_BIT_IN2      = 1;
	localparam int AAC_BIT_IN1      = 0;
	localparam int AAC_BIT_ROUTE    = 9;
	localparam int AAC_BIT_DIVIDER  = 8;
	localparam int AAC_BIT_REF2     = 1;
	localparam int AAC_BIT_REF1     = 0;

	// reset values
	localparam logic [15:0] AAC_RST_RESULT  = 16'h0000;
	localparam logic [15:0] AAC_RST_CONTROL = 16'h0000;
	localparam logic [15:0] AAC_RST_SELECT  = 16'h0000;
	localparam logic [15:0] AAC_RST_CONFIG  = 16'h0100;

	// origin tags, also used as channel codes on the converter port
	localparam logic [1:0] AAC_CH_NONE   = 2'h0;
	localparam logic [1:0] AAC_CH_IN1    = 2'h1;
	localparam logic [1:0] AAC_CH_IN2    = 2'h2;
	localparam logic [1:0] AAC_CH_SUPPLY = 2'h3;

	// timing
	localparam int AAC_CLK_HZ          = 50_000_000;
	localparam int AAC_RATE_STEP_HZ    = 16;
	localparam int AAC_RATE_DIV_CYCLES = AAC_CLK_HZ / AAC_RATE_STEP_HZ;

	typedef enum logic [0:0]
	{
		AAC_ST_IDLE = 1'b0,
		AAC_ST_BUSY = 1'b1
	} aac_state_e;

	// register port request
	typedef struct packed
	{
		logic        wr;
		logic        rd;
		logic [7:0]  idx;
		logic [15:0] wdata;
	} aac_reg_req_s;

	// one finished measurement
	typedef struct packed
	{
		logic        done;
		logic        pen;
		logic [11:0] data;
	} aac_meas_s;

	// next enabled channel after last, order first, second, supply
	function automatic logic [1:0] aac_next_chan(input logic [1:0] last,
		input logic [2:0] sel);
		logic [1:0] c;
		logic [1:0] res;
		c = last;
		res = AAC_CH_NONE;
		for (int i = 0; i < 3; i++)
		begin
			c = (c == AAC_CH_SUPPLY) ? AAC_CH_IN1 : c + 2'h1;
			if (res == AAC_CH_NONE && sel[c - 2'h1])
				res = c;
		end
		return res;
	endfunction : aac_next_chan

endpackage : aac_pkg

/* File: verilog/aac_rate_div.sv */
// Purpose: conversion rate enable, code times step frequency
// Assumes: single clock, synchronous reset
// Notes:   phase accumulator, exact average rate, one-cycle tick
`timescale 1ns/100ps
`default_nettype none
module aac_rate_div
	import aac_pkg::*;
#(
	parameter int DIV_CYCLES = AAC_RATE_DIV_CYCLES
)
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	// control
	input  wire logic       run_i,
	input  wire logic [4:0] rate_i,
	// enable out
	output logic            tick_o
);

	localparam logic [22:0] THR = 23'(DIV_CYCLES);

	typedef struct packed
	{
		logic [22:0] acc;
		logic        tick;
	} aac_div_s;

	aac_div_s s_r;
	aac_div_s s_nxt;
	logic [22:0] sum;

	// accumulate rate code, fire when threshold passed
	always_comb
	begin
		s_nxt = s_r;
		sum = s_r.acc + {18'h0, rate_i};
		s_nxt.tick = 1'b0;
		if (!run_i)
			s_nxt.acc = 23'h0;
		else if (sum >= THR)
		begin
			s_nxt.acc = sum - THR;
			s_nxt.tick = 1'b1;
		end
		else
			s_nxt.acc = sum;
	end

	// state register
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick_o = s_r.tick;

endmodule : aac_rate_div
`default_nettype wire

/* File: verilog/aac_regs.sv */
// Purpose: auxiliary converter control and result registers
// Assumes: register port already decoded from the serial control port
// Notes:   read data valid one cycle after rd, unmapped reads zero
`timescale 1ns/100ps
`default_nettype none
module aac_regs
	import aac_pkg::*;
#(
	parameter int DIV_CYCLES = AAC_RATE_DIV_CYCLES
)
(
	// clock and reset
	input  wire logic         clk_sys_i,
	input  wire logic         reset_i,
	// register port
	input  wire aac_reg_req_s reg_req_i,
	output logic [15:0]       reg_rdata_o,
	output logic              reg_rvalid_o,
	// converter port
	output logic              conv_start_o,
	output logic [1:0]        conv_chan_o,
	input  wire aac_meas_s    conv_meas_i,
	// touch pressure measurement
	input  wire aac_meas_s    touch_meas_i,
	// analogue settings
	output logic              aux_converter_on_o,
	output logic              supply_filter_route_o,
	output logic              supply_divider_sel_o,
	output logic              input_two_reference_o,
	output logic              input_one_reference_o
);

	typedef struct packed
	{
		aac_state_e  st;
		logic [15:0] pressure;
		logic [15:0] result;
		logic        on;
		logic        go;
		logic [4:0]  rate;
		logic [2:0]  sel;     // supply, second, first
		logic        route;
		logic        divider;
		logic [1:0]  refs;    // second, first
		logic [1:0]  last;
		logic [1:0]  chan;
		logic        start;
		logic [15:0] rdata;
		logic        rvalid;
	} aac_regs_s;

	aac_regs_s s_r;
	aac_regs_s s_nxt;
	logic      tick;
	logic      auto_run;
	logic      wr_ctl;
	logic [1:0] pick;

	assign auto_run = s_r.on && s_r.go && (s_r.rate != 5'h00);
	assign wr_ctl   = reg_req_i.wr && (reg_req_i.idx == AAC_IDX_CONTROL);
	assign pick     = aac_next_chan(s_r.last, s_r.sel);

	// rate enable
	aac_rate_div #(
		.DIV_CYCLES (DIV_CYCLES)
	) u_div (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.run_i     (auto_run),
		.rate_i    (s_r.rate),
		.tick_o    (tick)
	);

	// next state
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.start = 1'b0;
		s_nxt.rvalid = 1'b0;
		// RULE1 RULE2 pressure capture
		if (touch_meas_i.done)
			s_nxt.pressure = {touch_meas_i.pen, 3'h0, touch_meas_i.data};
		// RULE4 RULE5 RULE6 RULE7 RULE11 start next channel
		unique case (s_r.st)
			AAC_ST_IDLE:
			begin
				if (s_r.on && s_r.rate == 5'h00 && s_r.go)
				begin
					s_nxt.go = 1'b0;
					if (pick != AAC_CH_NONE)
					begin
						s_nxt.start = 1'b1;
						s_nxt.chan = pick;
						s_nxt.last = pick;
						s_nxt.st = AAC_ST_BUSY;
					end
				end
				else if (auto_run && tick && pick != AAC_CH_NONE)
				begin
					s_nxt.start = 1'b1;
					s_nxt.chan = pick;
					s_nxt.last = pick;
					s_nxt.st = AAC_ST_BUSY;
				end
			end
			AAC_ST_BUSY:
			begin
				// RULE3 RULE11 value and tag together
				if (conv_meas_i.done)
				begin
					s_nxt.result = {2'h0, s_r.chan, conv_meas_i.data};
					s_nxt.st = AAC_ST_IDLE;
				end
				else if (!s_r.on)
					s_nxt.st = AAC_ST_IDLE;
			end
		endcase
		// RULE12 host writes, result indices not decoded
		if (reg_req_i.wr)
		begin
			unique case (reg_req_i.idx)
				AAC_IDX_CONTROL:
				begin
					s_nxt.on = reg_req_i.wdata[AAC_BIT_ON];
					// host set wins over self clear
					s_nxt.go = reg_req_i.wdata[AAC_BIT_GO];
					s_nxt.rate = reg_req_i.wdata[4:0];
				end
				AAC_IDX_SELECT:
					s_nxt.sel = {reg_req_i.wdata[AAC_BIT_SUPPLY],
						reg_req_i.wdata[AAC_BIT_IN2],
						reg_req_i.wdata[AAC_BIT_IN1]};
				AAC_IDX_CONFIG:
				begin
					s_nxt.route = reg_req_i.wdata[AAC_BIT_ROUTE];
					s_nxt.divider = reg_req_i.wdata[AAC_BIT_DIVIDER];
					s_nxt.refs = {reg_req_i.wdata[AAC_BIT_REF2],
						reg_req_i.wdata[AAC_BIT_REF1]};
				end
				default:
					s_nxt.rvalid = 1'b0;
			endcase
		end
		// read mux, registered
		if (reg_req_i.rd)
		begin
			s_nxt.rvalid = 1'b1;
			unique case (reg_req_i.idx)
				AAC_IDX_PRESSURE: s_nxt.rdata = s_r.pressure;
				AAC_IDX_RESULT:   s_nxt.rdata = s_r.result;
				AAC_IDX_CONTROL:
					s_nxt.rdata = {s_r.on, s_r.go, 9'h000, s_r.rate};
				AAC_IDX_SELECT:
					s_nxt.rdata = {7'h00, s_r.sel[2], 6'h00, s_r.sel[1:0]};
				AAC_IDX_CONFIG:
					s_nxt.rdata = {6'h00, s_r.route, s_r.divider, 6'h00,
						s_r.refs};
				default:          s_nxt.rdata = 16'h0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_sys_i)
	begin
		if (reset_i)
		begin
			s_r <= '0;
			s_r.st <= AAC_ST_IDLE;
			s_r.result <= AAC_RST_RESULT;
			// RULE9 divider resets to one
			s_r.divider <= AAC_RST_CONFIG[AAC_BIT_DIVIDER];
		end
		else
			s_r <= s_nxt;
	end

	// outputs
	assign reg_rdata_o           = s_r.rdata;
	assign reg_rvalid_o          = s_r.rvalid;
	assign conv_start_o          = s_r.start;
	assign conv_chan_o           = s_r.chan;
	assign aux_converter_on_o    = s_r.on;
	// RULE8 RULE9 RULE10 analogue settings
	assign supply_filter_route_o = s_r.route;
	assign supply_divider_sel_o  = s_r.divider;
	assign input_two_reference_o = s_r.refs[1];
	assign input_one_reference_o = s_r.refs[0];

	// checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	AST_PEN_BIT: assert property ( // RULE1
		touch_meas_i.done |=> s_r.pressure[15] == $past(touch_meas_i.pen))
		else $error("pen flag not captured");
	AST_Z_DATA: assert property ( // RULE2
		touch_meas_i.done |=> s_r.pressure[11:0] == $past(touch_meas_i.data))
		else $error("pressure data not captured");
	AST_RESULT_TAG: assert property ( // RULE3
		(s_r.st == AAC_ST_BUSY && conv_meas_i.done) |=>
		(s_r.result == {2'h0, $past(s_r.chan), $past(conv_meas_i.data)}))
		else $error("result and tag mismatch");
	AST_AUTO_NEEDS_GO: assert property ( // RULE4
		(conv_start_o && $past(s_r.rate) != 5'h00) |-> $past(s_r.go))
		else $error("auto start without go");
	AST_MANUAL_CLEAR: assert property ( // RULE5
		(s_r.st == AAC_ST_IDLE && s_r.on && s_r.rate == 5'h00 && s_r.go
		&& !wr_ctl) |=> (!s_r.go &&
		(conv_start_o == ($past(pick) != AAC_CH_NONE))))
		else $error("manual go not cleared");
	AST_TICK_RATE: assert property ( // RULE6
		tick |-> $past(auto_run))
		else $error("tick while not running");
	// channel index taken at launch time, not from the new channel code
	AST_SELECTED: assert property ( // RULE7
		conv_start_o |-> (conv_chan_o != AAC_CH_NONE &&
		$past(s_r.sel[pick - 2'h1])))
		else $error("start on deselected channel");
	AST_ROUTE: assert property ( // RULE8
		(reg_req_i.wr && reg_req_i.idx == AAC_IDX_CONFIG) |=>
		supply_filter_route_o == $past(reg_req_i.wdata[AAC_BIT_ROUTE]))
		else $error("route not written");
	AST_DIV_RESET: assert property ( // RULE9
		$fell(reset_i) |-> supply_divider_sel_o)
		else $error("divider reset value wrong");
	AST_REFS: assert property ( // RULE10
		(reg_req_i.wr && reg_req_i.idx == AAC_IDX_CONFIG) |=>
		{input_two_reference_o, input_one_reference_o} ==
		{$past(reg_req_i.wdata[1]), $past(reg_req_i.wdata[0])})
		else $error("references not written");
	AST_ORDER: assert property ( // RULE11
		conv_start_o |-> conv_chan_o == $past(pick))
		else $error("channel order broken");
	AST_RO: assert property ( // RULE12
		(reg_req_i.wr && reg_req_i.idx == AAC_IDX_RESULT &&
		!conv_meas_i.done) |=> $stable(s_r.result))
		else $error("result written by host");

	COV_MANUAL: cover property (wr_ctl ##[1:3] conv_start_o);
	COV_AUTO: cover property (auto_run && conv_start_o);
	COV_DONE: cover property (conv_start_o ##[1:20] conv_meas_i.done);

endmodule : aac_regs
`default_nettype wire

/* File: verification/aac_conv_model.sv */
// Purpose: converter model answering each start with one measurement
// Assumes: one conversion at a time, started by a one-cycle pulse
// Notes:   latency 1 to 6 cycles, lines scramble outside the done pulse
`timescale 1ns/100ps
`default_nettype none
module aac_conv_model
	import aac_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	// request from the block
	input  wire logic       start_i,
	input  wire logic [1:0] chan_i,
	// measurement back
	output aac_meas_s       meas_o,
	output logic [11:0]     last_o
);
	int          wait_r;
	logic [11:0] val;
	aac_meas_s   scr;

	// random latency, data tagged with the channel in its top bits
	always @(posedge clk_sys_i)
	begin
		val = {chan_i, 10'($urandom)};
		scr = '{1'b0, ~meas_o.pen, ~meas_o.data};
		if (reset_i)
		begin
			wait_r <= 0;
			scr = '0;
		end
		else if (start_i)
			wait_r <= 1 + int'($urandom % 6);
		else if (wait_r == 1)
		begin
			scr = '{1'b1, 1'b0, val};
			last_o <= val;
			wait_r <= 0;
		end
		else if (wait_r > 1)
			wait_r <= wait_r - 1;
		// one update of the lines per edge
		meas_o <= scr;
	end
endmodule : aac_conv_model
`default_nettype wire

/* File: verification/aac_regs_tb.sv */
// Purpose: self-checking bench of the auxiliary converter registers
// Assumes: converter model answers every start
// Notes:   short rate divider so automatic mode runs quickly
`timescale 1ns/100ps
`default_nettype none
module aac_regs_tb
	import aac_pkg::*;
;
	localparam int DIV = 200;
	logic         clk_sys_i;
	logic         reset_i;
	aac_reg_req_s req;
	logic [15:0]  rdata;
	logic         rvalid;
	logic         start;
	logic [1:0]   chan;
	aac_meas_s    meas;
	aac_meas_s    touch;
	logic [11:0]  last;
	logic         on, route, dsel, ref2, ref1;
	int           err_total, n_checks, cyc, starts, rt;
	logic [15:0]  v;
	logic [2:0]   sel;
	logic [1:0]   lc;

	aac_regs #(.DIV_CYCLES(DIV)) uut (.clk_sys_i(clk_sys_i),
		.reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .conv_start_o(start), .conv_chan_o(chan),
		.conv_meas_i(meas), .touch_meas_i(touch),
		.aux_converter_on_o(on), .supply_filter_route_o(route),
		.supply_divider_sel_o(dsel), .input_two_reference_o(ref2),
		.input_one_reference_o(ref1));
	aac_conv_model model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.start_i(start), .chan_i(chan), .meas_o(meas), .last_o(last));

	// clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end

	// start counter and hang guard
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (start === 1'b1)
			starts++;
		if (cyc == 20000)
		begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		@(negedge clk_sys_i);
		req = '{1'b1, 1'b0, idx, d};
		@(negedge clk_sys_i);
		req.wr = 1'b0;
	endtask : wr

	// read, answer expected one cycle after the request
	task automatic rdc(input logic [7:0] idx, input logic [15:0] exp);
		@(negedge clk_sys_i);
		req = '{1'b0, 1'b1, idx, 16'h0000};
		@(negedge clk_sys_i);
		req.rd = 1'b0;
		chk({15'h0000, rvalid}, 16'h0001);
		chk(rdata, exp);
	endtask : rdc

	// next enabled channel after l, order first, second, supply
	function automatic logic [1:0] nxt(input logic [1:0] l,
		input logic [2:0] s);
		for (int i = 1; i <= 3; i++)
			if (s[(l + i - 1) % 3])
				return 2'((l + i - 1) % 3 + 1);
		return 2'h0;
	endfunction : nxt

	task automatic wait_done();
		int n;
		n = 0;
		while (meas.done !== 1'b1 && n < 60)
		begin
			@(negedge clk_sys_i);
			n++;
		end
		chk({15'h0000, meas.done}, 16'h0001);
		@(negedge clk_sys_i);
	endtask : wait_done

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	// main sequence
	initial
	begin
		req = '0;
		touch = '0;
		reset_i = 1'b1;
		{err_total, n_checks, cyc, starts} = '0;
		void'($urandom(55));
		repeat (3) @(negedge clk_sys_i);
		reset_i = 1'b0;
		rdc(AAC_IDX_PRESSURE, 16'h0000);
		rdc(AAC_IDX_RESULT, 16'h0000);
		rdc(AAC_IDX_CONFIG, 16'h0100);
		chk({15'h0000, dsel}, 16'h0001);
		$display("test reset done");
		repeat (4)
		begin
			v = 16'($urandom) & 16'h0303;
			wr(AAC_IDX_CONFIG, v);
			rdc(AAC_IDX_CONFIG, v);
			chk({12'h000, route, dsel, ref2, ref1},
				{12'h000, v[9], v[8], v[1], v[0]});
			v = 16'($urandom);
			wr(AAC_IDX_SELECT, v);
			rdc(AAC_IDX_SELECT, v & 16'h0103);
		end
		$display("test settings done");
		repeat (3)
		begin
			v = 16'($urandom);
			@(negedge clk_sys_i);
			touch = '{1'b1, v[15], v[11:0]};
			@(negedge clk_sys_i);
			touch = '{1'b0, ~v[15], ~v[11:0]};
			rdc(AAC_IDX_PRESSURE, v & 16'h8fff);
		end
		wr(AAC_IDX_PRESSURE, 16'hffff);
		rdc(AAC_IDX_PRESSURE, v & 16'h8fff);
		wr(AAC_IDX_RESULT, 16'hffff);
		rdc(AAC_IDX_RESULT, 16'h0000);
		wr(8'h40, 16'hffff);
		rdc(8'h40, 16'h0000);
		$display("test touch and read-only done");
		// second reset mid-run, then single conversions
		@(negedge clk_sys_i);
		reset_i = 1'b1;
		@(negedge clk_sys_i);
		reset_i = 1'b0;
		rdc(AAC_IDX_CONFIG, 16'h0100);
		sel = 3'($urandom % 7 + 1);
		wr(AAC_IDX_SELECT, {7'h00, sel[2], 6'h00, sel[1:0]});
		lc = 2'h0;
		repeat (4)
		begin
			wr(AAC_IDX_CONTROL, 16'hc000);
			wait_done();
			lc = nxt(lc, sel);
			chk({14'h0000, chan}, {14'h0000, lc});
			rdc(AAC_IDX_RESULT, {2'h0, lc, last});
			rdc(AAC_IDX_CONTROL, 16'h8000);
			chk({15'h0000, on}, 16'h0001);
		end
		$display("test manual done");
		wr(AAC_IDX_SELECT, 16'h0103);
		for (int k = 0; k < 3; k++)
		begin
			rt = (k == 0) ? 1 : (k == 1) ? 8 : 2 + int'($urandom % 6);
			wr(AAC_IDX_CONTROL, 16'hc000 | 16'(rt));
			starts = 0;
			repeat (2000) @(negedge clk_sys_i);
			chk({15'h0000, starts >= 10 * rt - 2 && starts <= 10 * rt + 1},
				16'h0001);
			wr(AAC_IDX_CONTROL, 16'h8000 | 16'(rt));
			// a start launched on the stopping edge is counted one edge late
			@(negedge clk_sys_i);
			starts = 0;
			repeat (300) @(negedge clk_sys_i);
			chk(16'(starts), 16'h0000);
		end
		$display("test automatic done");
		end_sim();
	end
endmodule : aac_regs_tb
`default_nettype wire
